// [verilog/pvmc_pkg.sv]
package pvmc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [5:0] AUTONEG_EXPANSION_IDX = 6'h06;
  localparam logic [5:0] PHY_VENDOR_CONFIG_IDX = 6'h10;
  localparam logic [15:0] AUTONEG_EXPANSION_RESET = 16'h0000;
  localparam logic [15:0] PHY_VENDOR_CONFIG_RESET = 16'h0140;
  localparam logic [15:0] PHY_VENDOR_CONFIG_WMASK = 16'hdc33;
  localparam int REPEATER_MODE_BIT = 15;
  localparam int IRQ_ACTIVE_LEVEL_BIT = 14;
  localparam int TX_HIGH_IMPEDANCE_BIT = 12;
  localparam int HEARTBEAT_TEST_INHIBIT_BIT = 11;
  localparam int NATURAL_LOOPBACK_BIT = 10;
  localparam int AUTO_POLARITY_DISABLE_BIT = 5;
  localparam int RX_POLARITY_INVERT_BIT = 4;
  localparam int CODING_SUBLAYER_BYPASS_BIT = 1;
  localparam int RX_CLOCK_GATING_BIT = 0;
  localparam logic [1:0] AXI_RESP_OKAY = 2'h0;
  localparam logic [1:0] AXI_RESP_SLVERR = 2'h2;
  localparam int HEARTBEAT_DELAY_NS = 1000;
  localparam int HEARTBEAT_WIDTH_NS = 1000;
  localparam int HEARTBEAT_DELAY_CYCLES = (HEARTBEAT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HEARTBEAT_WIDTH_CYCLES = (HEARTBEAT_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    PVMC_SEL_NONE = 2'b00,
    PVMC_SEL_EXP = 2'b01,
    PVMC_SEL_CFG = 2'b10
  } pvmc_sel_e;
  typedef enum logic [1:0] {
    PVMC_HB_IDLE = 2'b00,
    PVMC_HB_WAIT = 2'b01,
    PVMC_HB_PULSE = 2'b10
  } pvmc_hb_e;
endpackage

// [verilog/pvmc_rx_path.sv]
`timescale 1ns/10ps
module pvmc_rx_path
  import pvmc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic mode_10bt,
  input wire logic natural_loopback,
  input wire logic auto_polarity_disable,
  input wire logic forced_invert,
  input wire logic tx_en,
  input wire logic [3:0] tx_data,
  input wire logic line_rx_dv,
  input wire logic [3:0] line_rx_data,
  input wire logic rx_polarity_reversed,
  output logic rx_dv,
  output logic [3:0] rx_data,
  output logic auto_inverted
);
  typedef struct packed {
    logic rx_dv;
    logic [3:0] rx_data;
    logic auto_inverted;
  } pvmc_rx_s;

  pvmc_rx_s st;
  pvmc_rx_s next_st;
  logic invert;

  always_comb begin
    next_st = st;
    // Detector is only trusted on a 10BASE-T link; otherwise keep last verdict
    if (!auto_polarity_disable && mode_10bt) begin
      next_st.auto_inverted = rx_polarity_reversed;
    end
    invert = auto_polarity_disable ? forced_invert : st.auto_inverted;
    if (natural_loopback && mode_10bt) begin
      next_st.rx_dv = tx_en;
      next_st.rx_data = tx_data;
    end else begin
      next_st.rx_dv = line_rx_dv;
      next_st.rx_data = invert ? ~line_rx_data : line_rx_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rx_dv = st.rx_dv;
  assign rx_data = st.rx_data;
  assign auto_inverted = st.auto_inverted;
endmodule

// [verilog/pvmc_regs.sv]
// Overview of operation
// - Expansion register at index 0x06 reports negotiation and next-page capabilities.
// - Expansion register is read-only, zero after reset, writes ignored.
// - Vendor config at index 0x10 is writable, resets 0x0140, reserved bits fixed.
// - Natural loopback in 10BASE-T returns transmit data onto receive path.
// - Auto-polarity disable stops automatic receive pair inversion in 10BASE-T.
// - Receive polarity bit reports inversion, or forces it when auto-polarity off.
// - Coding bypass acts only in forced 100BASE-TX with negotiation off.
// - Receive clock gating in 100BASE-TX when idle, overridden by basic loopback.
`timescale 1ns/10ps
module pvmc_regs
  import pvmc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] expansion_status,
  input wire logic mode_10bt,
  input wire logic mode_100tx,
  input wire logic autoneg_enable,
  input wire logic basic_loopback,
  input wire logic tx_en,
  input wire logic [3:0] tx_data,
  input wire logic line_rx_dv,
  input wire logic [3:0] line_rx_data,
  input wire logic rx_polarity_reversed,
  input wire logic phy_irq_event,
  output logic rx_dv,
  output logic [3:0] rx_data,
  output logic carrier_sense,
  output logic full_duplex_allowed,
  output logic phy_irq,
  output logic tx_pins_hiz,
  output logic heartbeat,
  output logic pcs_bypass_active,
  output logic rx_clk_enable
);
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [7:0] waddr;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [15:0] rdata;
    logic [1:0] rresp;
    logic [15:0] expansion;
    logic [15:0] config_bits;
    logic phy_irq;
    logic tx_pins_hiz;
    logic carrier_sense;
    logic full_duplex_allowed;
    logic pcs_bypass_active;
    logic rx_clk_enable;
    logic tx_en_d;
    pvmc_hb_e hb_state;
    logic [7:0] hb_count;
    logic heartbeat;
  } pvmc_state_s;

  pvmc_state_s st;
  pvmc_state_s next_st;
  logic auto_inverted;
  logic [15:0] config_view;
  logic [15:0] wmask;
  logic [31:0] unused_bits;

  function automatic pvmc_sel_e addr_sel(input logic [7:0] addr);
    pvmc_sel_e sel;
    sel = PVMC_SEL_NONE;
    if (addr[7:2] == AUTONEG_EXPANSION_IDX) begin
      sel = PVMC_SEL_EXP;
    end else if (addr[7:2] == PHY_VENDOR_CONFIG_IDX) begin
      sel = PVMC_SEL_CFG;
    end
    return sel;
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old_val, input logic [15:0] new_val,
                                        input logic [15:0] mask);
    return (old_val & ~mask) | (new_val & mask);
  endfunction

  // Reserved fields always read the fixed reset pattern
  always_comb begin
    config_view = merge(PHY_VENDOR_CONFIG_RESET, st.config_bits, PHY_VENDOR_CONFIG_WMASK);
    if (!st.config_bits[AUTO_POLARITY_DISABLE_BIT]) begin
      config_view[RX_POLARITY_INVERT_BIT] = auto_inverted;
    end
  end

  always_comb begin
    wmask = PHY_VENDOR_CONFIG_WMASK & {{8{st.wstrb[1]}}, {8{st.wstrb[0]}}};
    // The forced value can be written only while auto-polarity is off
    if (!st.config_bits[AUTO_POLARITY_DISABLE_BIT]) begin
      wmask[RX_POLARITY_INVERT_BIT] = 1'b0;
    end
  end

  always_comb begin
    next_st = st;
    // Write address and data are taken independently, in either order
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_got = 1'b1;
      next_st.awready = 1'b0;
      next_st.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_got = 1'b1;
      next_st.wready = 1'b0;
      next_st.wdata = s_axi_wdata[15:0];
      next_st.wstrb = s_axi_wstrb[1:0];
    end
    if (st.aw_got && st.w_got && !st.bvalid) begin
      next_st.bvalid = 1'b1;
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      unique case (addr_sel(st.waddr))
        PVMC_SEL_CFG: begin
          next_st.config_bits = merge(st.config_bits, st.wdata, wmask);
          next_st.bresp = AXI_RESP_OKAY;
        end
        PVMC_SEL_EXP: begin
          next_st.bresp = AXI_RESP_OKAY;
        end
        default: begin
          next_st.bresp = AXI_RESP_SLVERR;
        end
      endcase
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
    end
    if (s_axi_arvalid && st.arready) begin
      next_st.arready = 1'b0;
      next_st.rvalid = 1'b1;
      unique case (addr_sel(s_axi_araddr))
        PVMC_SEL_EXP: begin
          next_st.rdata = st.expansion;
          next_st.rresp = AXI_RESP_OKAY;
        end
        PVMC_SEL_CFG: begin
          next_st.rdata = config_view;
          next_st.rresp = AXI_RESP_OKAY;
        end
        default: begin
          next_st.rdata = 16'h0000;
          next_st.rresp = AXI_RESP_SLVERR;
        end
      endcase
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end
    // Hardware status only; the bus never writes it
    next_st.expansion = expansion_status;
    if (st.config_bits[IRQ_ACTIVE_LEVEL_BIT]) begin
      next_st.phy_irq = phy_irq_event;
    end else begin
      next_st.phy_irq = ~phy_irq_event;
    end
    next_st.tx_pins_hiz = st.config_bits[TX_HIGH_IMPEDANCE_BIT];
    // A repeater must not see its own transmission as carrier
    if (st.config_bits[REPEATER_MODE_BIT]) begin
      next_st.carrier_sense = line_rx_dv;
      next_st.full_duplex_allowed = 1'b0;
    end else begin
      next_st.carrier_sense = line_rx_dv | tx_en;
      next_st.full_duplex_allowed = 1'b1;
    end
    next_st.pcs_bypass_active = st.config_bits[CODING_SUBLAYER_BYPASS_BIT]
                                & mode_100tx & ~autoneg_enable;
    next_st.rx_clk_enable = ~(st.config_bits[RX_CLOCK_GATING_BIT] & mode_100tx & ~line_rx_dv)
                            | basic_loopback;
    next_st.tx_en_d = tx_en;
    next_st.heartbeat = 1'b0;
    unique case (st.hb_state)
      PVMC_HB_IDLE: begin
        if (st.tx_en_d && !tx_en && mode_10bt && !st.config_bits[HEARTBEAT_TEST_INHIBIT_BIT]) begin
          next_st.hb_state = PVMC_HB_WAIT;
          next_st.hb_count = 8'(HEARTBEAT_DELAY_CYCLES - 1);
        end
      end
      PVMC_HB_WAIT: begin
        if (st.hb_count == 8'h00) begin
          next_st.hb_state = PVMC_HB_PULSE;
          next_st.hb_count = 8'(HEARTBEAT_WIDTH_CYCLES - 1);
          next_st.heartbeat = 1'b1;
        end else begin
          next_st.hb_count = st.hb_count - 8'h01;
        end
      end
      PVMC_HB_PULSE: begin
        if (st.hb_count == 8'h00) begin
          next_st.hb_state = PVMC_HB_IDLE;
        end else begin
          next_st.hb_count = st.hb_count - 8'h01;
          next_st.heartbeat = 1'b1;
        end
      end
      default: begin
        next_st.hb_state = PVMC_HB_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
      st.expansion <= AUTONEG_EXPANSION_RESET;
      st.config_bits <= PHY_VENDOR_CONFIG_RESET;
      // Reset level selects active low, so the idle pin sits high
      st.phy_irq <= 1'b1;
      st.full_duplex_allowed <= 1'b1;
      st.rx_clk_enable <= 1'b1;
      st.hb_state <= PVMC_HB_IDLE;
    end else begin
      st <= next_st;
    end
  end

  pvmc_rx_path u_rx_path (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode_10bt(mode_10bt),
    .natural_loopback(st.config_bits[NATURAL_LOOPBACK_BIT]),
    .auto_polarity_disable(st.config_bits[AUTO_POLARITY_DISABLE_BIT]),
    .forced_invert(st.config_bits[RX_POLARITY_INVERT_BIT]),
    .tx_en(tx_en),
    .tx_data(tx_data),
    .line_rx_dv(line_rx_dv),
    .line_rx_data(line_rx_data),
    .rx_polarity_reversed(rx_polarity_reversed),
    .rx_dv(rx_dv),
    .rx_data(rx_data),
    .auto_inverted(auto_inverted)
  );

  // Protection bits and upper data lanes carry no meaning here
  assign unused_bits = {s_axi_wdata[31:16], s_axi_wstrb[3:2], s_axi_awprot, s_axi_arprot,
                        8'h00};

  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = {16'h0000, st.rdata};
  assign s_axi_rresp = st.rresp;
  assign carrier_sense = st.carrier_sense;
  assign full_duplex_allowed = st.full_duplex_allowed;
  assign phy_irq = st.phy_irq;
  assign tx_pins_hiz = st.tx_pins_hiz;
  assign heartbeat = st.heartbeat;
  assign pcs_bypass_active = st.pcs_bypass_active;
  assign rx_clk_enable = st.rx_clk_enable;
endmodule

// [tb/pvmc_regs_sva.sv]
`timescale 1ns/10ps
module pvmc_regs_sva
  import pvmc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mode_100tx,
  input wire logic autoneg_enable,
  input wire logic basic_loopback,
  input wire logic pcs_bypass_active,
  input wire logic rx_clk_enable
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_aw_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_b_seen;
    ##[1:3] s_axi_bvalid;
  endsequence
  property p_wr_resp; s_aw_take |-> s_b_seen; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("no write response");
  property p_ar_take;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_ar_take: assert property (p_ar_take) else $error("read answer late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  property p_r_upper;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0
                     && (s_axi_rresp == AXI_RESP_OKAY || s_axi_rdata == 32'h0);
  endproperty
  a_r_upper: assert property (p_r_upper) else $error("read data upper bits set");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response not held");
  property p_aw_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_aw_refuse: assert property (p_aw_refuse) else $error("write taken while busy");
  property p_pcs; pcs_bypass_active |-> $past(mode_100tx && !autoneg_enable); endproperty
  a_pcs: assert property (p_pcs) else $error("bypass outside forced mode");
  property p_rxclk; $past(basic_loopback) |-> rx_clk_enable; endproperty
  a_rxclk: assert property (p_rxclk) else $error("clock gated in loopback");
endmodule
bind pvmc_regs pvmc_regs_sva u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mode_100tx,
  .autoneg_enable, .basic_loopback, .pcs_bypass_active, .rx_clk_enable);

// [tb/pvmc_regs_tb.sv]
`timescale 1ns/10ps
module pvmc_regs_tb
  import pvmc_pkg::*;
;
  logic aclk = 0, aresetn = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h3, tx_data = 0, line_rx_data = 0, rx_data;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [15:0] expansion_status = 0;
  logic mode_10bt = 0, mode_100tx = 0, autoneg_enable = 0, basic_loopback = 0, tx_en = 0;
  logic line_rx_dv = 0, rx_polarity_reversed = 0, phy_irq_event = 0;
  logic rx_dv, carrier_sense, full_duplex_allowed, phy_irq, tx_pins_hiz, heartbeat;
  logic pcs_bypass_active, rx_clk_enable;
  logic [31:0] rd_v;
  logic [1:0] rs;
  localparam logic [7:0] EXP_ADDR = {AUTONEG_EXPANSION_IDX, 2'b00};
  localparam logic [7:0] CFG_ADDR = {PHY_VENDOR_CONFIG_IDX, 2'b00};
  int n_fail = 0, check_count = 0, cyc = 0;
  pvmc_regs dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .expansion_status, .mode_10bt, .mode_100tx,
    .autoneg_enable, .basic_loopback, .tx_en, .tx_data, .line_rx_dv, .line_rx_data,
    .rx_polarity_reversed, .phy_irq_event, .rx_dv, .rx_data, .carrier_sense,
    .full_duplex_allowed, .phy_irq, .tx_pins_hiz, .heartbeat, .pcs_bypass_active, .rx_clk_enable);
  always #5 aclk = ~aclk;
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Hang guard: the whole sequence needs about 630 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Address and data are each released at their own handshake edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    fork
      begin do @(posedge aclk); while (s_axi_awready !== 1); s_axi_awvalid <= 0; end
      begin do @(posedge aclk); while (s_axi_wready !== 1); s_axi_wvalid <= 0; end
    join
    do @(posedge aclk); while (s_axi_bvalid !== 1);
    rs = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (s_axi_rvalid !== 1);
    rd_v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic settle();
    repeat (4) @(posedge aclk);
  endtask
  task automatic t_exp();
    rd(EXP_ADDR);
    chk(rd_v, 32'h0);
    @(posedge aclk);
    expansion_status <= 16'h000b;
    settle();
    rd(EXP_ADDR);
    chk(rd_v, 32'h000b);
    wr(EXP_ADDR, 16'hffff);
    chk(32'(rs), 32'(AXI_RESP_OKAY));
    rd(EXP_ADDR);
    chk(rd_v, 32'h000b);
    $display("test expansion done");
  endtask
  task automatic t_cfg();
    rd(CFG_ADDR);
    chk(rd_v, 32'h0140);
    wr(CFG_ADDR, 16'hffff);
    rd(CFG_ADDR);
    chk(rd_v, 32'hdd63);
    wr(CFG_ADDR, 16'hffff);
    rd(CFG_ADDR);
    chk(rd_v, 32'hdd73);
    settle();
    chk(32'(tx_pins_hiz), 32'h1);
    chk(32'(full_duplex_allowed), 32'h0);
    $display("test config done");
  endtask
  task automatic t_irq();
    @(posedge aclk);
    phy_irq_event <= 1;
    settle();
    chk(32'(phy_irq), 32'h1);
    wr(CFG_ADDR, 16'h0000);
    settle();
    chk(32'(phy_irq), 32'h0);
    rd(CFG_ADDR);
    chk(rd_v, 32'h0140);
    $display("test interrupt level done");
  endtask
  task automatic t_pol();
    @(posedge aclk);
    mode_10bt <= 1;
    rx_polarity_reversed <= 1;
    line_rx_dv <= 1;
    line_rx_data <= 4'h5;
    settle();
    rd(CFG_ADDR);
    chk(rd_v, 32'h0150);
    chk(32'(rx_data), 32'ha);
    wr(CFG_ADDR, 16'h0020);
    settle();
    chk(32'(rx_data), 32'h5);
    wr(CFG_ADDR, 16'h0030);
    settle();
    chk(32'(rx_data), 32'ha);
    rd(CFG_ADDR);
    chk(rd_v, 32'h0170);
    $display("test polarity done");
  endtask
  // Line valid is dropped so that a looped valid cannot be mistaken for the line's
  task automatic t_loop();
    wr(CFG_ADDR, 16'h0400);
    @(posedge aclk);
    tx_en <= 1;
    tx_data <= 4'h3;
    line_rx_dv <= 0;
    settle();
    chk(32'(rx_data), 32'h3);
    chk(32'(rx_dv), 32'h1);
    @(posedge aclk);
    mode_10bt <= 0;
    settle();
    chk(32'(rx_data), 32'ha);
    chk(32'(rx_dv), 32'h0);
    @(posedge aclk);
    tx_en <= 0;
    $display("test loopback done");
  endtask
  task automatic t_pcs();
    wr(CFG_ADDR, 16'h0002);
    @(posedge aclk);
    mode_100tx <= 1;
    autoneg_enable <= 1;
    settle();
    chk(32'(pcs_bypass_active), 32'h0);
    @(posedge aclk);
    autoneg_enable <= 0;
    settle();
    chk(32'(pcs_bypass_active), 32'h1);
    $display("test bypass done");
  endtask
  task automatic t_rxclk();
    wr(CFG_ADDR, 16'h0001);
    @(posedge aclk);
    line_rx_dv <= 0;
    settle();
    chk(32'(rx_clk_enable), 32'h0);
    @(posedge aclk);
    basic_loopback <= 1;
    settle();
    chk(32'(rx_clk_enable), 32'h1);
    $display("test clock gating done");
  endtask
  task automatic t_bad();
    rd(8'h20);
    chk(rd_v, 32'h0);
    chk(32'(rs), 32'(AXI_RESP_SLVERR));
    wr(8'h24, 16'h1234);
    chk(32'(rs), 32'(AXI_RESP_SLVERR));
    $display("test unmapped done");
  endtask
  // Sampled at falling edges, so the first count already covers the edge that drops tx_en
  task automatic t_hb();
    int n;
    @(posedge aclk);
    mode_100tx <= 0;
    mode_10bt <= 1;
    tx_en <= 1;
    settle();
    chk(32'(carrier_sense), 32'h1);
    chk(32'(rx_dv), 32'h0);
    chk(32'(heartbeat), 32'h0);
    @(posedge aclk);
    tx_en <= 0;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (heartbeat !== 1'b1 && n < 300);
    chk(32'(n), 32'(HEARTBEAT_DELAY_CYCLES + 2));
    n = 0;
    while (heartbeat === 1'b1 && n < 300) begin
      @(negedge aclk);
      n++;
    end
    chk(32'(n), 32'(HEARTBEAT_WIDTH_CYCLES));
    wr(CFG_ADDR, 16'h8800);
    @(posedge aclk);
    tx_en <= 1;
    settle();
    chk(32'(carrier_sense), 32'h0);
    chk(32'(full_duplex_allowed), 32'h0);
    @(posedge aclk);
    tx_en <= 0;
    n = 0;
    repeat (250) begin
      @(negedge aclk);
      if (heartbeat !== 1'b0) begin
        n++;
      end
    end
    chk(32'(n), 32'h0);
    @(posedge aclk);
    mode_10bt <= 0;
    $display("test heartbeat done");
  endtask
  task automatic t_rst();
    @(posedge aclk);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(CFG_ADDR);
    chk(rd_v, 32'h0140);
    chk(32'(full_duplex_allowed), 32'h1);
    @(posedge aclk);
    s_axi_wstrb <= 4'h2;
    wr(CFG_ADDR, 16'hffff);
    rd(CFG_ADDR);
    chk(rd_v, 32'hdd40);
    @(posedge aclk);
    s_axi_wstrb <= 4'h1;
    wr(CFG_ADDR, 16'hffff);
    rd(CFG_ADDR);
    chk(rd_v, 32'hdd63);
    @(posedge aclk);
    s_axi_wstrb <= 4'h3;
    $display("test reset and lanes done");
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    t_exp();
    t_cfg();
    t_irq();
    t_pol();
    t_loop();
    t_pcs();
    t_rxclk();
    t_bad();
    t_hb();
    t_rst();
    print_verdict();
  end
endmodule
